// ### rtl/mrs_pkg.sv
// Contract
// - three reset causes only: pin, software request, watchdog underflow; all restart at vector.
// - reset pin sampled low with supply in range enters hardware reset.
// - pin low forces pins and oscillators to initial state and starts main clock.
// - cpu and registers released on pin rising edge, then fetch from vector; code raises core_resetn 5 clocks after the edge, one clock after start_fetch.
// - hardware reset leaves internal ram contents unchanged.
// - ram write caught by reset may hold an undefined value.
// - while pin low every port pin is a high-impedance input.
// - pull-up state undefined until internal voltage has settled.
// - writing 1 to software reset request bit resets cpu, registers, pins; code keeps the vector register across it.
// - watchdog underflow with watchdog reset select at 1 resets cpu, registers, pins; code keeps the vector register across it.
// - start address is vector upper 30 bits with low two bits 00b.
// - in microprocessor mode vector low two bits select external bus width.
package mrs_pkg;
	// ==========================================
	// register map
	localparam logic [11:0] mrs_reg_proc_mode = 12'h000;
	localparam logic [11:0] mrs_reg_clk_ctrl  = 12'h004;
	localparam logic [11:0] mrs_reg_status    = 12'h008;
	localparam logic [11:0] mrs_reg_vector    = 12'h00C;
	localparam logic [11:0] mrs_reg_start     = 12'h010;
	// ==========================================
	// field positions
	localparam int mrs_bit_sw_req     = 3;
	localparam int mrs_bit_micro_mode = 0;
	localparam int mrs_bit_wdt_sel    = 6;
	localparam int mrs_bit_cause_pin  = 0;
	localparam int mrs_bit_cause_sw   = 1;
	localparam int mrs_bit_cause_wdt  = 2;
	localparam int mrs_bit_running    = 3;
	// ==========================================
	// timing and reset values
	localparam int mrs_min_osc_cycles   = 20;
	localparam int mrs_release_cycles   = 2;
	localparam logic [4:0] mrs_cnt_max  = 5'h1F;
	localparam logic [31:0] mrs_vector_reset = 32'h0000_0000;
	localparam logic [1:0] mrs_align_zero = 2'h0;
	localparam int mrs_port_width = 8;

	typedef enum logic [1:0] {
		mrs_st_hold    = 2'b00,
		mrs_st_release = 2'b01,
		mrs_st_run     = 2'b10
	} mrs_state_type;
endpackage : mrs_pkg

// ### rtl/mrs_reset_seq.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq
	import mrs_pkg::*;
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      wdt_underflow,
	input  wire logic [mrs_port_width-1:0] port_out_func,
	input  wire logic [mrs_port_width-1:0] port_oe_func,
	output logic      [mrs_port_width-1:0] port_out,
	output logic      [mrs_port_width-1:0] port_oe,
	output logic                           core_resetn,
	output logic                           osc_init,
	output logic                           main_osc_enable,
	output logic                           ram_write_block,
	output logic      [31:0]               start_address,
	output logic      [1:0]                ext_bus_width,
	output logic                           start_fetch
);
	// ==========================================
	// pin reset synchroniser
	logic sync_a;
	logic sync_b;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= 1'b1;
			sync_b <= sync_a;
		end
	end

	// ==========================================
	// sequencer state
	mrs_state_type state;
	mrs_state_type next_state;
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic [3:0]  cause;
	logic [3:0]  next_cause;
	logic        micro_mode;
	logic        next_micro_mode;
	logic        wdt_sel;
	logic        next_wdt_sel;
	logic [31:0] vector;
	logic [31:0] next_vector;
	logic [31:0] next_prdata;
	logic        soft_req;
	logic        wdt_req;
	logic        wr_en;
	logic        rd_en;

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == mrs_reg_proc_mode) || (a == mrs_reg_clk_ctrl) || (a == mrs_reg_status)
			|| (a == mrs_reg_vector) || (a == mrs_reg_start);
	endfunction : addr_hit

	assign wr_en    = psel && penable && pwrite;
	// read data is loaded in the setup cycle so it stands through the access phase
	assign rd_en    = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_hit(paddr);
	assign soft_req = wr_en && (paddr == mrs_reg_proc_mode) && pwdata[mrs_bit_sw_req];
	assign wdt_req  = wdt_underflow && wdt_sel;

	always_comb begin
		next_state      = state;
		next_cnt        = cnt;
		next_cause      = cause;
		next_micro_mode = micro_mode;
		next_wdt_sel    = wdt_sel;
		next_vector     = vector;
		next_prdata     = prdata;
		unique case (state)
			mrs_st_hold: begin
				next_cnt = cnt + 5'h01;
				if (int'(cnt) >= mrs_release_cycles - 1) begin
					next_state = mrs_st_release;
				end
			end
			mrs_st_release: begin
				next_state = mrs_st_run;
				next_cause[mrs_bit_running] = 1'b1;
			end
			mrs_st_run: begin
				if (wr_en && (paddr == mrs_reg_proc_mode)) begin
					next_micro_mode = pwdata[mrs_bit_micro_mode];
				end
				if (wr_en && (paddr == mrs_reg_clk_ctrl)) begin
					next_wdt_sel = pwdata[mrs_bit_wdt_sel];
				end
				if (wr_en && (paddr == mrs_reg_vector)) begin
					next_vector = pwdata;
				end
				if (soft_req || wdt_req) begin
					next_state = mrs_st_hold;
					next_cnt   = 5'h00;
					next_cause = 4'h0;
					next_cause[mrs_bit_cause_sw]  = soft_req;
					next_cause[mrs_bit_cause_wdt] = wdt_req && !soft_req;
					next_wdt_sel    = 1'b0;
					next_micro_mode = 1'b0;
				end
			end
			default: begin
				next_state = mrs_st_hold;
			end
		endcase
		if (rd_en) begin
			unique case (paddr)
				mrs_reg_proc_mode: next_prdata = {31'h0, micro_mode};
				mrs_reg_clk_ctrl:  next_prdata = {25'h0, wdt_sel, 6'h00};
				mrs_reg_status:    next_prdata = {28'h0, cause};
				mrs_reg_vector:    next_prdata = vector;
				mrs_reg_start:     next_prdata = {vector[31:2], mrs_align_zero};
				default:           next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= mrs_st_hold;
			cnt        <= 5'h00;
			cause      <= 4'h1;
			micro_mode <= 1'b0;
			wdt_sel    <= 1'b0;
			vector     <= mrs_vector_reset;
			prdata     <= 32'h0000_0000;
		end else if (!sync_b) begin
			state      <= mrs_st_hold;
			cnt        <= 5'h00;
			cause      <= 4'h1;
			micro_mode <= 1'b0;
			wdt_sel    <= 1'b0;
			prdata     <= 32'h0000_0000;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			cause      <= next_cause;
			micro_mode <= next_micro_mode;
			wdt_sel    <= next_wdt_sel;
			vector     <= next_vector;
			prdata     <= next_prdata;
		end
	end

	// ==========================================
	// outputs
	logic in_reset;
	assign in_reset        = (state != mrs_st_run);
	assign core_resetn     = !in_reset;
	assign osc_init        = !sync_b;
	assign main_osc_enable = 1'b1;
	assign ram_write_block = in_reset;
	assign port_out        = in_reset ? {mrs_port_width{1'b0}} : port_out_func;
	assign port_oe         = in_reset ? {mrs_port_width{1'b0}} : port_oe_func;
	assign start_address   = {vector[31:2], mrs_align_zero};
	assign ext_bus_width   = micro_mode ? vector[1:0] : mrs_align_zero;
	assign start_fetch     = (state == mrs_st_release);

	// ==========================================
	// checks
	chk_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_b && state == mrs_st_run && soft_req) |=> (!core_resetn && cause[mrs_bit_cause_sw]))
		else $error("software request did not reset");
	chk_wdt_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_b && state == mrs_st_run && wdt_underflow && wdt_sel) |=> !core_resetn)
		else $error("watchdog reset missed");
	chk_wdt_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_b && state == mrs_st_run && wdt_underflow && !wdt_sel && !soft_req) |=> core_resetn)
		else $error("watchdog reset without select");
	chk_ports_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		!core_resetn |-> (port_oe == '0))
		else $error("port driven during reset");
	chk_align_start: assert property (@(posedge pclk) disable iff (!presetn)
		start_address[1:0] == 2'b00 && start_address[31:2] == vector[31:2])
		else $error("start address misaligned");
	chk_release_seq: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sync_b) |=> ##1 start_fetch ##1 core_resetn)
		else $error("release sequence wrong");
	chk_fetch_once: assert property (@(posedge pclk) disable iff (!presetn)
		start_fetch |=> !start_fetch)
		else $error("fetch strobe too long");
	chk_bus_width: assert property (@(posedge pclk) disable iff (!presetn)
		!micro_mode |-> ext_bus_width == 2'b00)
		else $error("bus width in single chip");
	chk_ram_guard: assert property (@(posedge pclk) disable iff (!presetn)
		!core_resetn |-> ram_write_block)
		else $error("ram writable in reset");
	chk_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!sync_b |=> !core_resetn)
		else $error("pin low did not hold reset");
	chk_osc_running: assert property (@(posedge pclk) disable iff (!presetn)
		main_osc_enable)
		else $error("main oscillator stopped");
	chk_osc_init: assert property (@(posedge pclk) disable iff (!presetn)
		!sync_b |-> osc_init)
		else $error("oscillator not initialised");
	chk_port_out_low: assert property (@(posedge pclk) disable iff (!presetn)
		!core_resetn |-> (port_out == '0))
		else $error("port output not initial in reset");
	chk_cause_single: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0(cause[mrs_bit_cause_wdt:mrs_bit_cause_pin]))
		else $error("more than one reset cause");
	chk_wdt_cause: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_b && state == mrs_st_run && wdt_req && !soft_req) |=> cause[mrs_bit_cause_wdt])
		else $error("watchdog cause not recorded");
	chk_bus_micro: assert property (@(posedge pclk) disable iff (!presetn)
		micro_mode |-> (ext_bus_width == vector[1:0]))
		else $error("bus width not from vector");
	chk_vector_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_b && state == mrs_st_run && soft_req) |=> $stable(vector))
		else $error("vector lost on software reset");
	chk_ram_free: assert property (@(posedge pclk) disable iff (!presetn)
		core_resetn |-> !ram_write_block)
		else $error("ram blocked while running");
	chk_hold_count: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_b && state == mrs_st_hold) |-> (int'(cnt) < mrs_release_cycles))
		else $error("hold count overran");
	chk_ports_pass: assert property (@(posedge pclk) disable iff (!presetn)
		core_resetn |-> (port_oe == port_oe_func))
		else $error("ports not released after reset");
endmodule : mrs_reset_seq
`default_nettype wire

// ### sim/mrs_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_pin_driver
	import mrs_pkg::*;
(
	input  wire logic pclk,
	input  wire logic pin_req,
	output logic      presetn
);
	// ====================
	// pin low while asked, then at least the minimum clock count
	int count;
	initial begin
		presetn = 1'b0;
		count = 0;
		forever begin
			@(posedge pclk);
			if (pin_req) begin
				presetn <= 1'b0;
				count = 0;
			end else if (count < mrs_min_osc_cycles) begin
				count++;
			end else begin
				presetn <= 1'b1;
			end
		end
	end
endmodule : mrs_pin_driver
`default_nettype wire

// ### sim/mrs_reset_seq_test.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq_test;
	import mrs_pkg::*;
	logic        pclk, presetn, pin_req, psel, penable, pwrite, pready, pslverr, wdt_underflow;
	logic        core_resetn, osc_init, main_osc_enable, ram_write_block, start_fetch, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, start_address, q;
	logic [7:0]  port_out, port_oe;
	logic [1:0]  ext_bus_width;
	int          mismatches, check_count, cycles;
	mrs_pin_driver mrs_pin_driver_i (.pclk(pclk), .pin_req(pin_req), .presetn(presetn));
	mrs_reset_seq mrs_reset_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wdt_underflow(wdt_underflow), .port_out_func(8'hA5),
		.port_oe_func(8'hFF), .port_out(port_out), .port_oe(port_oe), .core_resetn(core_resetn),
		.osc_init(osc_init), .main_osc_enable(main_osc_enable), .ram_write_block(ram_write_block),
		.start_address(start_address), .ext_bus_width(ext_bus_width), .start_fetch(start_fetch));
	// ====================
	// helpers
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : apb
	task automatic run_wait(input logic [31:0] status);
		int n;
		logic fetched;
		n = 0;
		fetched = 1'b0;
		while (core_resetn !== 1'b0 && n < 8) begin
			@(posedge pclk);
			n++;
		end
		check("reset entered", core_resetn, 0);
		check("ram guard", ram_write_block, 1);
		n = 0;
		while (core_resetn !== 1'b1 && n < 60) begin
			@(posedge pclk);
			if (start_fetch === 1'b1) fetched = 1'b1;
			n++;
		end
		check("fetch", fetched, 1);
		check("core", core_resetn, 1);
		check("ports", port_oe, 8'hFF);
		check("port out run", port_out, 8'hA5);
		apb(0, mrs_reg_status, 0);
		check("status", q, status);
	endtask : run_wait
	task automatic pin_reset;
		@(posedge pclk);
		pin_req <= 1'b1;
		repeat (6) @(posedge pclk);
		check("port oe", port_oe, 0);
		check("port out", port_out, 0);
		check("osc", {osc_init, main_osc_enable}, 2'h3);
		pin_req <= 1'b0;
		run_wait(32'h9);
		check("start", start_address, 0);
		$display("pin reset done");
	endtask : pin_reset
	task automatic t_vector;
		apb(1, mrs_reg_vector, 32'h0001_2344);
		check("start addr", start_address, 32'h0001_2344);
		check("width single", ext_bus_width, 0);
		apb(1, mrs_reg_proc_mode, 32'h1);
		apb(1, mrs_reg_vector, 32'h0001_2347);
		check("width micro", ext_bus_width, 2'h3);
		apb(0, mrs_reg_start, 0);
		check("start reg", q, 32'h0001_2344);
		apb(0, 12'h020, 0);
		check("unmapped", {err, q}, {1'b1, 32'h0});
		$display("vector done");
	endtask : t_vector
	task automatic t_soft;
		apb(1, mrs_reg_proc_mode, 32'h9);
		run_wait(32'hA);
		check("mode cleared", ext_bus_width, 0);
		apb(0, mrs_reg_vector, 0);
		check("vector kept", q, 32'h0001_2347);
		$display("soft reset done");
	endtask : t_soft
	task automatic t_wdt;
		@(posedge pclk);
		wdt_underflow <= 1'b1;
		@(posedge pclk);
		wdt_underflow <= 1'b0;
		repeat (8) @(posedge pclk);
		check("no wdt reset", core_resetn, 1);
		apb(1, mrs_reg_clk_ctrl, 32'h40);
		@(posedge pclk);
		wdt_underflow <= 1'b1;
		@(posedge pclk);
		wdt_underflow <= 1'b0;
		run_wait(32'hC);
		$display("watchdog done");
	endtask : t_wdt
	// ====================
	// clock, timeout, sequence
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		{psel, penable, pwrite, wdt_underflow} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pin_req = 1'b1;
		{mismatches, check_count, cycles} = 0;
		pin_reset();
		t_vector();
		t_soft();
		t_wdt();
		pin_reset();
		conclude();
	end
endmodule : mrs_reset_seq_test
`default_nettype wire
